// ===== include/cpfc_pkg.sv
// Purpose: shared constants and types for the multifunction pin control block
// Assumes: byte-wide register port, offsets fixed below
// Notes: field positions and codes named once here
package cpfc_pkg;

  // register offsets
  localparam logic [7:0] CPFC_OFF_PRIMARY = 8'h40;
  localparam logic [7:0] CPFC_OFF_SECONDARY = 8'h41;

  // reset values
  localparam logic [7:0] CPFC_RST_PRIMARY = 8'h3F;
  localparam logic [7:0] CPFC_RST_SECONDARY = 8'h00;

  // field positions
  localparam int CPFC_PWR_LSB = 6;
  localparam int CPFC_SELB_LSB = 3;
  localparam int CPFC_SELA_LSB = 0;
  localparam int CPFC_SECB_LSB = 4;
  localparam int CPFC_SECA_LSB = 0;

  // power pin function codes
  localparam logic [1:0] CPFC_PWR_POWERDOWN = 2'h0;
  localparam logic [1:0] CPFC_PWR_STANDBY = 2'h1;
  localparam logic [1:0] CPFC_PWR_IGNORED = 2'h2;

  // primary selector codes
  localparam logic [2:0] CPFC_SEL_FAST_DETECT = 3'h0;
  localparam logic [2:0] CPFC_SEL_LMFC = 3'h1;
  localparam logic [2:0] CPFC_SEL_SECONDARY = 3'h6;
  localparam logic [2:0] CPFC_SEL_DISABLED = 3'h7;

  // secondary function codes
  localparam logic [3:0] CPFC_SEC_OSC_SELECT = 4'h0;
  localparam logic [3:0] CPFC_SEC_TRANSFER_IN = 4'h1;
  localparam logic [3:0] CPFC_SEC_NEXT_TRIG_OUT = 4'h8;
  localparam logic [3:0] CPFC_SEC_NEXT_TRIG_IN = 4'h9;

  // chip power state forced by the external pin
  typedef enum logic [1:0] {
    CPFC_PWR_NORMAL,
    CPFC_PWR_STBY,
    CPFC_PWR_FULL_DOWN
  } cpfc_pwr_e;

  // resolved role of one multifunction pin
  typedef enum logic [2:0] {
    CPFC_ROLE_FAST_DETECT,
    CPFC_ROLE_LMFC,
    CPFC_ROLE_OSC_SELECT,
    CPFC_ROLE_TRANSFER_IN,
    CPFC_ROLE_NEXT_TRIG_OUT,
    CPFC_ROLE_NEXT_TRIG_IN,
    CPFC_ROLE_PULLDOWN_IN
  } cpfc_role_e;

  // register write request
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpfc_wr_s;

endpackage

// ===== hdl/cpfc_pin_mux.sv
// Purpose: decode one multifunction pin's selector and secondary field
// Assumes: codes from cpfc_pkg
// Notes: purely combinational, registered by the parent
`timescale 1ns/100ps
module cpfc_pin_mux
(
  input wire logic [2:0] sel,
  input wire logic [3:0] sec,
  output cpfc_pkg::cpfc_role_e role
);

  // secondary field only matters at the secondary selector code
  always_comb
  begin
    case (sel)
      cpfc_pkg::CPFC_SEL_FAST_DETECT: role = cpfc_pkg::CPFC_ROLE_FAST_DETECT;
      cpfc_pkg::CPFC_SEL_LMFC: role = cpfc_pkg::CPFC_ROLE_LMFC;
      cpfc_pkg::CPFC_SEL_SECONDARY:
      begin
        case (sec)
          cpfc_pkg::CPFC_SEC_OSC_SELECT: role = cpfc_pkg::CPFC_ROLE_OSC_SELECT;
          cpfc_pkg::CPFC_SEC_TRANSFER_IN: role = cpfc_pkg::CPFC_ROLE_TRANSFER_IN;
          cpfc_pkg::CPFC_SEC_NEXT_TRIG_OUT: role = cpfc_pkg::CPFC_ROLE_NEXT_TRIG_OUT;
          cpfc_pkg::CPFC_SEC_NEXT_TRIG_IN: role = cpfc_pkg::CPFC_ROLE_NEXT_TRIG_IN;
          default: role = cpfc_pkg::CPFC_ROLE_PULLDOWN_IN;
        endcase
      end
      cpfc_pkg::CPFC_SEL_DISABLED: role = cpfc_pkg::CPFC_ROLE_PULLDOWN_IN;
      default: role = cpfc_pkg::CPFC_ROLE_PULLDOWN_IN;
    endcase
  end

endmodule // cpfc_pin_mux

// ===== hdl/cpfc_top.sv
// Purpose: pin function control for power-down/standby input and two multifunction pins
// Assumes: register port synchronous to core_clk, pins sampled synchronously
// Notes: every output registered; pin roles take effect one cycle after a write
//
// What this block does
// - an active power pin overrides the per-channel power mode request
// - power pin acts only with global field 00 or 01
// - field 00 (reset) makes the asserted pin force full power-down
// - field 01 makes the asserted pin force standby
// - field 10 ignores the power pin completely
// - pin B selector 000 outputs fast-detect B, 001 outputs LMFC
// - pin B selector 110 uses the upper secondary field
// - pin B selector 111 (reset) is disabled weak pull-down input
// - pin A selector 000 outputs fast-detect A, 001 outputs LMFC
// - pin A selector 110 uses the lower secondary field
// - pin A selector 111 (reset) is disabled weak pull-down input
// - pin B secondary field only used at selector 110, resets to zero
// - secondary code 0000 is an input steering oscillator channel choice
// - code 0001 transfer input, 1000 next-trigger out, 1001 next-trigger in
`timescale 1ns/100ps
module cpfc_top
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic power_down_standby_input,
  input wire logic [1:0] channel_power_mode,
  output logic [1:0] chip_power_mode,
  output logic chip_standby,
  output logic chip_full_power_down,
  input wire logic fast_detect_a,
  input wire logic fast_detect_b,
  input wire logic lmfc,
  input wire logic master_next_trigger_out,
  input wire logic multifunction_pin_a_in,
  output logic multifunction_pin_a_out,
  output logic multifunction_pin_a_oe,
  output logic multifunction_pin_a_pulldown,
  input wire logic multifunction_pin_b_in,
  output logic multifunction_pin_b_out,
  output logic multifunction_pin_b_oe,
  output logic multifunction_pin_b_pulldown,
  output logic [1:0] numeric_oscillator_select,
  output logic chip_transfer_request,
  output logic slave_next_trigger_in
);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  cpfc_pkg::cpfc_wr_s wr;
  logic [7:0] pin_control_primary_reg;
  logic [7:0] pin_control_secondary_reg;
  logic [1:0] pwr_field;
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  logic [3:0] sec_a;
  logic [3:0] sec_b;

  assign wr = '{wr_en: reg_wr_en, addr: reg_addr, wdata: reg_wdata};
  assign pwr_field = pin_control_primary_reg[cpfc_pkg::CPFC_PWR_LSB +: 2];
  assign sel_b = pin_control_primary_reg[cpfc_pkg::CPFC_SELB_LSB +: 3];
  assign sel_a = pin_control_primary_reg[cpfc_pkg::CPFC_SELA_LSB +: 3];
  assign sec_b = pin_control_secondary_reg[cpfc_pkg::CPFC_SECB_LSB +: 4];
  assign sec_a = pin_control_secondary_reg[cpfc_pkg::CPFC_SECA_LSB +: 4];

  // primary control: power field and both selectors, reset to pin idle state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_control_primary_reg <= cpfc_pkg::CPFC_RST_PRIMARY;
    else if (wr.wr_en && wr.addr == cpfc_pkg::CPFC_OFF_PRIMARY)
      pin_control_primary_reg <= wr.wdata;
  end

  // secondary control: two four-bit secondary function fields
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_control_secondary_reg <= cpfc_pkg::CPFC_RST_SECONDARY;
    else if (wr.wr_en && wr.addr == cpfc_pkg::CPFC_OFF_SECONDARY)
      pin_control_secondary_reg <= wr.wdata;
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_addr == cpfc_pkg::CPFC_OFF_PRIMARY)
      reg_rdata <= pin_control_primary_reg;
    else if (reg_addr == cpfc_pkg::CPFC_OFF_SECONDARY)
      reg_rdata <= pin_control_secondary_reg;
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down / standby pin

  cpfc_pkg::cpfc_pwr_e pin_pwr;

  // field 11 is undocumented, treated like disabled
  always_comb
  begin
    pin_pwr = cpfc_pkg::CPFC_PWR_NORMAL;
    if (power_down_standby_input)
    begin
      case (pwr_field)
        cpfc_pkg::CPFC_PWR_POWERDOWN: pin_pwr = cpfc_pkg::CPFC_PWR_FULL_DOWN;
        cpfc_pkg::CPFC_PWR_STANDBY: pin_pwr = cpfc_pkg::CPFC_PWR_STBY;
        cpfc_pkg::CPFC_PWR_IGNORED: pin_pwr = cpfc_pkg::CPFC_PWR_NORMAL;
        default: pin_pwr = cpfc_pkg::CPFC_PWR_NORMAL;
      endcase
    end
  end

  // pin state wins over the channel power mode request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_power_mode <= 2'h0;
      chip_standby <= 1'b0;
      chip_full_power_down <= 1'b0;
    end
    else
    begin
      chip_standby <= (pin_pwr == cpfc_pkg::CPFC_PWR_STBY);
      chip_full_power_down <= (pin_pwr == cpfc_pkg::CPFC_PWR_FULL_DOWN);
      if (pin_pwr == cpfc_pkg::CPFC_PWR_NORMAL)
        chip_power_mode <= channel_power_mode;
      else
        chip_power_mode <= 2'h0; // override, mode request masked
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multifunction pins

  cpfc_pkg::cpfc_role_e role_a;
  cpfc_pkg::cpfc_role_e role_b;

  cpfc_pin_mux u_mux_a
  (
    .sel(sel_a),
    .sec(sec_a),
    .role(role_a)
  );

  cpfc_pin_mux u_mux_b
  (
    .sel(sel_b),
    .sec(sec_b),
    .role(role_b)
  );

  // pin A drivers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      multifunction_pin_a_out <= 1'b0;
      multifunction_pin_a_oe <= 1'b0;
      multifunction_pin_a_pulldown <= 1'b1;
    end
    else
    begin
      multifunction_pin_a_pulldown <= (role_a == cpfc_pkg::CPFC_ROLE_PULLDOWN_IN);
      case (role_a)
        cpfc_pkg::CPFC_ROLE_FAST_DETECT:
        begin
          multifunction_pin_a_out <= fast_detect_a;
          multifunction_pin_a_oe <= 1'b1;
        end
        cpfc_pkg::CPFC_ROLE_LMFC:
        begin
          multifunction_pin_a_out <= lmfc;
          multifunction_pin_a_oe <= 1'b1;
        end
        cpfc_pkg::CPFC_ROLE_NEXT_TRIG_OUT:
        begin
          multifunction_pin_a_out <= master_next_trigger_out;
          multifunction_pin_a_oe <= 1'b1;
        end
        default:
        begin
          multifunction_pin_a_out <= 1'b0;
          multifunction_pin_a_oe <= 1'b0;
        end
      endcase
    end
  end

  // pin B drivers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      multifunction_pin_b_out <= 1'b0;
      multifunction_pin_b_oe <= 1'b0;
      multifunction_pin_b_pulldown <= 1'b1;
    end
    else
    begin
      multifunction_pin_b_pulldown <= (role_b == cpfc_pkg::CPFC_ROLE_PULLDOWN_IN);
      case (role_b)
        cpfc_pkg::CPFC_ROLE_FAST_DETECT:
        begin
          multifunction_pin_b_out <= fast_detect_b;
          multifunction_pin_b_oe <= 1'b1;
        end
        cpfc_pkg::CPFC_ROLE_LMFC:
        begin
          multifunction_pin_b_out <= lmfc;
          multifunction_pin_b_oe <= 1'b1;
        end
        cpfc_pkg::CPFC_ROLE_NEXT_TRIG_OUT:
        begin
          multifunction_pin_b_out <= master_next_trigger_out;
          multifunction_pin_b_oe <= 1'b1;
        end
        default:
        begin
          multifunction_pin_b_out <= 1'b0;
          multifunction_pin_b_oe <= 1'b0;
        end
      endcase
    end
  end

  // input roles; a pin not in a role contributes zero so stale levels never leak
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      numeric_oscillator_select <= 2'h0;
      chip_transfer_request <= 1'b0;
      slave_next_trigger_in <= 1'b0;
    end
    else
    begin
      numeric_oscillator_select <=
        {(role_b == cpfc_pkg::CPFC_ROLE_OSC_SELECT) & multifunction_pin_b_in,
         (role_a == cpfc_pkg::CPFC_ROLE_OSC_SELECT) & multifunction_pin_a_in};
      chip_transfer_request <=
        ((role_a == cpfc_pkg::CPFC_ROLE_TRANSFER_IN) & multifunction_pin_a_in) |
        ((role_b == cpfc_pkg::CPFC_ROLE_TRANSFER_IN) & multifunction_pin_b_in);
      slave_next_trigger_in <=
        ((role_a == cpfc_pkg::CPFC_ROLE_NEXT_TRIG_IN) & multifunction_pin_a_in) |
        ((role_b == cpfc_pkg::CPFC_ROLE_NEXT_TRIG_IN) & multifunction_pin_b_in);
    end
  end

endmodule // cpfc_top

// ===== sim/cpfc_checker.sv
// Purpose: port-level assertions for the pin function control block
// Assumes: one clock, register effects land one edge after the write
// Notes: control registers are shadowed from the write port
`timescale 1ns/100ps
module cpfc_checker
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic power_down_standby_input,
  input wire logic [1:0] channel_power_mode,
  input wire logic [1:0] chip_power_mode,
  input wire logic chip_standby,
  input wire logic chip_full_power_down,
  input wire logic lmfc,
  input wire logic master_next_trigger_out,
  input wire logic multifunction_pin_a_out,
  input wire logic multifunction_pin_a_oe,
  input wire logic multifunction_pin_a_pulldown,
  input wire logic multifunction_pin_b_out,
  input wire logic multifunction_pin_b_oe,
  input wire logic multifunction_pin_b_pulldown
);
  logic [7:0] pri_reg;
  logic [7:0] sec_reg;
  wire logic pin_on = power_down_standby_input;
  // shadow copies; unmapped offsets must not disturb them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_reg <= cpfc_pkg::CPFC_RST_PRIMARY;
      sec_reg <= cpfc_pkg::CPFC_RST_SECONDARY;
    end
    else if (reg_wr_en && reg_addr == cpfc_pkg::CPFC_OFF_PRIMARY)
      pri_reg <= reg_wdata;
    else if (reg_wr_en && reg_addr == cpfc_pkg::CPFC_OFF_SECONDARY)
      sec_reg <= reg_wdata;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_full_down: assert property (
    pin_on && pri_reg[7:6] == 2'h0 |=> chip_full_power_down && !chip_standby
    && chip_power_mode == 2'h0) else $error("pin did not force full power-down");
  chk_standby_forced: assert property (
    pin_on && pri_reg[7:6] == 2'h1 |=> chip_standby && !chip_full_power_down
    && chip_power_mode == 2'h0) else $error("pin did not force standby");
  chk_pin_ignored: assert property (
    pri_reg[7] |=> !chip_standby && !chip_full_power_down) else $error("pin not ignored");
  chk_mode_passes: assert property (
    !pin_on || pri_reg[7] |=> chip_power_mode == $past(channel_power_mode))
    else $error("channel power mode not passed through");
  chk_lmfc_a: assert property (
    pri_reg[2:0] == 3'h1 |=> multifunction_pin_a_oe && multifunction_pin_a_out == $past(lmfc))
    else $error("pin a not driving lmfc");
  chk_pulldown_a: assert property (
    pri_reg[2:0] == 3'h7 |=> multifunction_pin_a_pulldown && !multifunction_pin_a_oe)
    else $error("pin a not a pulled-down input");
  chk_pulldown_b: assert property (
    pri_reg[5:3] == 3'h7 |=> multifunction_pin_b_pulldown && !multifunction_pin_b_oe)
    else $error("pin b not a pulled-down input");
  chk_trig_out_b: assert property (
    pri_reg[5:3] == 3'h6 && sec_reg[7:4] == 4'h8 |=> multifunction_pin_b_oe
    && multifunction_pin_b_out == $past(master_next_trigger_out)) else $error("pin b no trigger");
endmodule // cpfc_checker

bind cpfc_top cpfc_checker u_chk (.core_clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata,
  .power_down_standby_input, .channel_power_mode, .chip_power_mode, .chip_standby,
  .chip_full_power_down, .lmfc, .master_next_trigger_out, .multifunction_pin_a_out,
  .multifunction_pin_a_oe, .multifunction_pin_a_pulldown, .multifunction_pin_b_out,
  .multifunction_pin_b_oe, .multifunction_pin_b_pulldown);

// ===== sim/cpfc_board.sv
// Purpose: board-side model of the two multifunction pin wires
// Assumes: device drive wins over the board drive
// Notes: a wire nobody drives or pulls shows the inverse of its last level
`timescale 1ns/100ps
module cpfc_board
(
  input wire logic core_clk,
  input wire logic [1:0] dev_oe,
  input wire logic [1:0] dev_out,
  input wire logic [1:0] dev_pd,
  input wire logic [1:0] brd_en,
  input wire logic [1:0] brd_val,
  output logic [1:0] pin_lvl
);
  logic [1:0] last_reg = 2'h0;
  // weak pull-down only shows while nobody drives the wire
  always_comb
    for (int i = 0; i < 2; i++)
      pin_lvl[i] = dev_oe[i] ? dev_out[i] : brd_en[i] ? brd_val[i] : !dev_pd[i] & ~last_reg[i];
  always_ff @(posedge core_clk)
    last_reg <= pin_lvl;
endmodule // cpfc_board

// ===== sim/chip_pin_function_control_tb.sv
// Purpose: self-checking bench for the pin function control block
// Assumes: outputs registered one edge after their causes
// Notes: random register and pin traffic against an integer model
`timescale 1ns/100ps
module chip_pin_function_control_tb;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr_en = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic power_down_standby_input = 1'h0;
  logic [1:0] channel_power_mode = 2'h0;
  logic fast_detect_a = 1'h0, fast_detect_b = 1'h0, lmfc = 1'h0, master_next_trigger_out = 1'h0;
  logic [1:0] brd_en = 2'h0, brd_val = 2'h0, pin_lvl, chip_power_mode, numeric_oscillator_select;
  logic [7:0] reg_rdata;
  logic chip_standby, chip_full_power_down, chip_transfer_request, slave_next_trigger_in;
  logic multifunction_pin_a_out, multifunction_pin_a_oe, multifunction_pin_a_pulldown;
  logic multifunction_pin_b_out, multifunction_pin_b_oe, multifunction_pin_b_pulldown;
  int miscompares = 0, checks_done = 0, seed = 32'h1034, pri = 8'h3F, sec = 8'h00;
  cpfc_top DUT (.core_clk, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata,
    .power_down_standby_input, .channel_power_mode, .chip_power_mode, .chip_standby,
    .chip_full_power_down, .fast_detect_a, .fast_detect_b, .lmfc, .master_next_trigger_out,
    .multifunction_pin_a_in(pin_lvl[0]), .multifunction_pin_a_out, .multifunction_pin_a_oe,
    .multifunction_pin_a_pulldown, .multifunction_pin_b_in(pin_lvl[1]),
    .multifunction_pin_b_out, .multifunction_pin_b_oe, .multifunction_pin_b_pulldown,
    .numeric_oscillator_select, .chip_transfer_request, .slave_next_trigger_in);
  cpfc_board u_brd (.core_clk, .brd_en, .brd_val, .pin_lvl,
    .dev_oe({multifunction_pin_b_oe, multifunction_pin_a_oe}),
    .dev_out({multifunction_pin_b_out, multifunction_pin_a_out}),
    .dev_pd({multifunction_pin_b_pulldown, multifunction_pin_a_pulldown}));
  initial
    forever #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // expected {oe, out, pulldown, osc, transfer, trigger-in}; unlisted codes park
  function automatic logic [5:0] pin_exp(logic [2:0] sl, logic [3:0] sc, logic fd, logic lv);
    if (sl == 3'h0) return {1'h1, fd, 4'h0};
    if (sl == 3'h1) return {1'h1, lmfc, 4'h0};
    if (sl == 3'h6 && sc == 4'h0) return {3'h0, lv, 2'h0};
    if (sl == 3'h6 && sc == 4'h1) return {4'h0, lv, 1'h0};
    if (sl == 3'h6 && sc == 4'h8) return {1'h1, master_next_trigger_out, 4'h0};
    if (sl == 3'h6 && sc == 4'h9) return {5'h00, lv};
    return 6'h08;
  endfunction
  task automatic check(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // called at an edge, leaves at the edge that takes the write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr_en <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    if (a == 8'h40) pri = d;
    else if (a == 8'h41) sec = d;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr <= a;
    @(posedge core_clk);
    #1 check(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [5:0] ea, eb;
    logic [7:0] f, ep;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    check({6'h00, multifunction_pin_a_pulldown, multifunction_pin_b_pulldown}, 8'h03);
    rd(cpfc_pkg::CPFC_OFF_PRIMARY, 8'h3F);
    rd(cpfc_pkg::CPFC_OFF_SECONDARY, 8'h00);
    // back-to-back writes, then a stray write that must change nothing
    repeat (400)
    begin
      f = 8'($random(seed));
      if ($random(seed) & 1) f[5:0] = 6'h36;
      wr(cpfc_pkg::CPFC_OFF_PRIMARY, f);
      wr(cpfc_pkg::CPFC_OFF_SECONDARY, 8'($random(seed)));
      wr(8'h80 | 8'($random(seed)), 8'($random(seed)));
      reg_wr_en <= 1'h0;
      {power_down_standby_input, channel_power_mode, fast_detect_a, fast_detect_b, lmfc,
        master_next_trigger_out, brd_en, brd_val} <= 11'($random(seed));
      // take pin levels mid-cycle, the values the design samples at the next edge; at the edge they race
      @(negedge core_clk);
      ea = pin_exp(pri[2:0], sec[3:0], fast_detect_a, pin_lvl[0]);
      eb = pin_exp(pri[5:3], sec[7:4], fast_detect_b, pin_lvl[1]);
      ep = {4'h0, channel_power_mode, 2'h0};
      if (power_down_standby_input && pri[7:6] == 0) ep = 8'h01;
      if (power_down_standby_input && pri[7:6] == 1) ep = 8'h02;
      @(posedge core_clk);
      #1 check({5'h00, multifunction_pin_a_oe, multifunction_pin_a_oe & multifunction_pin_a_out,
        multifunction_pin_a_pulldown}, {5'h00, ea[5:3]});
      check({5'h00, multifunction_pin_b_oe, multifunction_pin_b_oe & multifunction_pin_b_out,
        multifunction_pin_b_pulldown}, {5'h00, eb[5:3]});
      check({4'h0, numeric_oscillator_select, chip_transfer_request, slave_next_trigger_in},
        {4'h0, eb[2], ea[2], ea[1] | eb[1], ea[0] | eb[0]});
      check({4'h0, chip_power_mode, chip_standby, chip_full_power_down}, ep);
      @(posedge core_clk);
      rd(cpfc_pkg::CPFC_OFF_PRIMARY, pri[7:0]);
      rd(cpfc_pkg::CPFC_OFF_SECONDARY, sec[7:0]);
    end
    report_and_stop();
  end
endmodule // chip_pin_function_control_tb
